// ### rtl/fcp_map.vh
// Register map, op codes, bus codes and timing constants of the flash command sequencer
//
// Function
// - Array-read bank answers plain reads
// - Reset command F0 leaves autoselect or status
// - Autoselect reads use bank address, id over three
// - Secure region entry and exit command sequences
// - Lock-bit program, verify bit zero, retry
// - Secure protection bit program and status
// - Erase all lock bits, verify zero, retry
// - Wait 1.2 ms between fourth and fifth cycle
// - Issue reset before retrying erase all
// - Freeze command 78, status 58 reads bit one
`ifndef FCP_MAP_VH
`define FCP_MAP_VH

// Software register byte offsets
`define FCP_REG_CMD 5'h00
`define FCP_REG_ADDR 5'h04
`define FCP_REG_DATA 5'h08
`define FCP_REG_STATUS 5'h0C
`define FCP_REG_RDATA 5'h10
`define FCP_REG_CTRL 5'h14

// Status bit positions
`define FCP_ST_BUSY 0
`define FCP_ST_DONE 1
`define FCP_ST_VFAIL 2
`define FCP_ST_REFUSED 3
`define FCP_ST_SECURE 4
`define FCP_ST_SUSP 5
`define FCP_ST_ERASE 6

// Operation codes written to the command register
`define FCP_OP_READ 5'h00
`define FCP_OP_RESET 5'h01
`define FCP_OP_PROG 5'h02
`define FCP_OP_SERASE 5'h03
`define FCP_OP_SUSPEND 5'h04
`define FCP_OP_RESUME 5'h05
`define FCP_OP_QUERY 5'h06
`define FCP_OP_AUTOSEL 5'h07
`define FCP_OP_SEC_ENTRY 5'h08
`define FCP_OP_SEC_EXIT 5'h09
`define FCP_OP_LOCK_PROG 5'h0A
`define FCP_OP_LOCK_STAT 5'h0B
`define FCP_OP_LOCK_ERASE 5'h0C
`define FCP_OP_FREEZE 5'h0D
`define FCP_OP_FREEZE_STAT 5'h0E
`define FCP_OP_SECP_PROG 5'h0F
`define FCP_OP_SECP_STAT 5'h10

// Step kinds and address selectors of the cycle table
`define FCP_K_END 2'h0
`define FCP_K_WR 2'h1
`define FCP_K_RD 2'h2
`define FCP_K_WAIT 2'h3
`define FCP_A_555 3'h0
`define FCP_A_2AA 3'h1
`define FCP_A_B555 3'h2
`define FCP_A_TGT 3'h3
`define FCP_A_LOCK 3'h4
`define FCP_A_SECL 3'h5
`define FCP_A_B055 3'h6
`define FCP_A_ZERO 3'h7

// Flash bus codes
`define FCP_LO_555 12'h555
`define FCP_LO_2AA 12'h2AA
`define FCP_LO_055 12'h055
`define FCP_LOCK_LO 8'h02
`define FCP_SECL_LO 8'h1A

// Timing
`define FCP_CLK_MHZ 25
`define FCP_ERASE_GAP_US 1200
`define FCP_WE_LOW_CYC 2
`define FCP_RD_CYC 5
`define FCP_MAX_RETRY 3

`endif

// ### rtl/fcp_sequencer.v
// Host-side command sequencer driving a parallel NOR flash through its pins
`timescale 1ns/100ps
`default_nettype none
`include "fcp_map.vh"

module fcp_sequencer #(
    parameter AW = 21,
    parameter [31:0] ERASE_GAP_CYC = `FCP_ERASE_GAP_US * `FCP_CLK_MHZ,
    parameter [3:0] MAX_RETRY = 4'd`FCP_MAX_RETRY
) (
    input wire clk,
    input wire sys_rst,
    input wire [4:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg [AW-1:0] flash_addr,
    output reg [15:0] flash_dq_o,
    output reg flash_dq_oe,
    input wire [15:0] flash_dq_i,
    output reg flash_ce_n,
    output reg flash_we_n,
    output reg flash_oe_n,
    output reg flash_reset_n
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_FETCH = 3'h1;
    localparam [2:0] S_WSETUP = 3'h2;
    localparam [2:0] S_WLOW = 3'h3;
    localparam [2:0] S_WHOLD = 3'h4;
    localparam [2:0] S_RLOW = 3'h5;
    localparam [2:0] S_WGAP = 3'h6;
    localparam [2:0] S_CHECK = 3'h7;
    localparam [15:0] GAP_LOAD = ERASE_GAP_CYC[15:0] - 16'h0001;
    localparam [15:0] WE_LOAD = 16'd`FCP_WE_LOW_CYC - 16'd1;
    localparam [15:0] RD_LOAD = 16'd`FCP_RD_CYC - 16'd1;

    reg [2:0] state_r; // Sequencer state
    reg [2:0] state_nxt; // Next sequencer state
    reg [4:0] op_r; // Operation in progress
    reg [2:0] idx_r; // Step within the operation
    reg [15:0] cnt_r; // Pulse and gap counter
    reg [3:0] retry_r; // Verify retries spent
    reg rst_first_r; // Insert a reset write before step zero
    reg [AW-1:0] tgt_r; // Target address register
    reg [15:0] data_r; // Program data register
    reg [15:0] rdata_r; // Last word read from the flash
    reg [15:0] dq_s1_r; // Pin synchroniser, first stage
    reg [15:0] dq_s2_r; // Pin synchroniser, second stage
    reg done_r; // Sticky: an operation finished
    reg vfail_r; // Sticky: verify failed after all retries
    reg refused_r; // Sticky: a command was refused
    reg secure_r; // Secure region mapped in
    reg susp_r; // Erase suspended
    reg erase_r; // Sector erase launched
    reg hw_reset_r; // Software holds the reset pin low
    reg [12:0] step; // Current table step
    reg [AW-1:0] amux; // Address for the current step
    wire [1:0] kind; // Kind field of the step
    wire [2:0] asel; // Address selector of the step
    wire [7:0] dbyte; // Command byte of the step
    wire [AW-13:0] bank; // Bank and sector bits above A11
    wire cmd_wr; // Software writes the command register
    wire refuse; // New command is not legal now
    wire need_one; // Final read must show bit zero set
    wire need_zero; // Final read must show bit zero clear
    wire verify_bad; // Final read disagrees with the goal
    wire finish; // Operation reaches its end step
    wire clr_wr; // Software writes the status register

    // ------------------------------------------------------------
    // Cycle table
    // ------------------------------------------------------------
    // Each operation is a list of {kind, address selector, byte}
    function [12:0] fcp_step;
        input [4:0] op;
        input [2:0] idx;
        reg unl;
        begin
            fcp_step = {`FCP_K_END, `FCP_A_ZERO, 8'h00};
            unl = (op == `FCP_OP_PROG) || (op == `FCP_OP_SERASE) || (op >= `FCP_OP_AUTOSEL);
            if (unl && idx == 3'd0)
                fcp_step = {`FCP_K_WR, `FCP_A_555, 8'hAA};
            else if (unl && idx == 3'd1)
                fcp_step = {`FCP_K_WR, `FCP_A_2AA, 8'h55};
            else
            begin
                case ({op, idx})
                    {`FCP_OP_READ, 3'd0}: fcp_step = {`FCP_K_RD, `FCP_A_TGT, 8'h00};
                    {`FCP_OP_RESET, 3'd0}: fcp_step = {`FCP_K_WR, `FCP_A_ZERO, 8'hF0};
                    {`FCP_OP_PROG, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'hA0};
                    {`FCP_OP_PROG, 3'd3}: fcp_step = {`FCP_K_WR, `FCP_A_TGT, 8'h00};
                    {`FCP_OP_SERASE, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'h80};
                    {`FCP_OP_SERASE, 3'd3}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'hAA};
                    {`FCP_OP_SERASE, 3'd4}: fcp_step = {`FCP_K_WR, `FCP_A_2AA, 8'h55};
                    {`FCP_OP_SERASE, 3'd5}: fcp_step = {`FCP_K_WR, `FCP_A_TGT, 8'h30};
                    {`FCP_OP_SUSPEND, 3'd0}: fcp_step = {`FCP_K_WR, `FCP_A_B555, 8'hB0};
                    {`FCP_OP_RESUME, 3'd0}: fcp_step = {`FCP_K_WR, `FCP_A_B555, 8'h30};
                    {`FCP_OP_QUERY, 3'd0}: fcp_step = {`FCP_K_WR, `FCP_A_B055, 8'h98};
                    {`FCP_OP_AUTOSEL, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_B555, 8'h90};
                    {`FCP_OP_AUTOSEL, 3'd3}: fcp_step = {`FCP_K_RD, `FCP_A_TGT, 8'h00};
                    {`FCP_OP_SEC_ENTRY, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'h88};
                    {`FCP_OP_SEC_EXIT, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'h90};
                    {`FCP_OP_SEC_EXIT, 3'd3}: fcp_step = {`FCP_K_WR, `FCP_A_ZERO, 8'h00};
                    {`FCP_OP_LOCK_PROG, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'h60};
                    {`FCP_OP_LOCK_PROG, 3'd3}: fcp_step = {`FCP_K_WR, `FCP_A_LOCK, 8'h68};
                    {`FCP_OP_LOCK_PROG, 3'd4}: fcp_step = {`FCP_K_WR, `FCP_A_LOCK, 8'h48};
                    {`FCP_OP_LOCK_PROG, 3'd5}: fcp_step = {`FCP_K_RD, `FCP_A_LOCK, 8'h00};
                    {`FCP_OP_LOCK_STAT, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_B555, 8'h90};
                    {`FCP_OP_LOCK_STAT, 3'd3}: fcp_step = {`FCP_K_RD, `FCP_A_LOCK, 8'h00};
                    {`FCP_OP_LOCK_ERASE, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'h60};
                    {`FCP_OP_LOCK_ERASE, 3'd3}: fcp_step = {`FCP_K_WR, `FCP_A_LOCK, 8'h60};
                    {`FCP_OP_LOCK_ERASE, 3'd4}: fcp_step = {`FCP_K_WAIT, `FCP_A_ZERO, 8'h00};
                    {`FCP_OP_LOCK_ERASE, 3'd5}: fcp_step = {`FCP_K_WR, `FCP_A_TGT, 8'h40};
                    {`FCP_OP_LOCK_ERASE, 3'd6}: fcp_step = {`FCP_K_RD, `FCP_A_LOCK, 8'h00};
                    {`FCP_OP_FREEZE, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'h78};
                    {`FCP_OP_FREEZE_STAT, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_B555, 8'h58};
                    {`FCP_OP_FREEZE_STAT, 3'd3}: fcp_step = {`FCP_K_RD, `FCP_A_TGT, 8'h00};
                    {`FCP_OP_SECP_PROG, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'h60};
                    {`FCP_OP_SECP_PROG, 3'd3}: fcp_step = {`FCP_K_WR, `FCP_A_SECL, 8'h68};
                    {`FCP_OP_SECP_PROG, 3'd4}: fcp_step = {`FCP_K_WR, `FCP_A_SECL, 8'h48};
                    {`FCP_OP_SECP_PROG, 3'd5}: fcp_step = {`FCP_K_RD, `FCP_A_SECL, 8'h00};
                    {`FCP_OP_SECP_STAT, 3'd2}: fcp_step = {`FCP_K_WR, `FCP_A_555, 8'h60};
                    {`FCP_OP_SECP_STAT, 3'd3}: fcp_step = {`FCP_K_WR, `FCP_A_SECL, 8'h48};
                    {`FCP_OP_SECP_STAT, 3'd4}: fcp_step = {`FCP_K_RD, `FCP_A_SECL, 8'h00};
                    default: fcp_step = {`FCP_K_END, `FCP_A_ZERO, 8'h00};
                endcase
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Step decode and address forming
    // ------------------------------------------------------------
    assign bank = tgt_r[AW-1:12];
    assign kind = step[12:11];
    assign asel = step[10:8];
    assign dbyte = step[7:0];

    // Pick the step, a reset write overrides when a retry needs one
    always @*
    begin
        if (rst_first_r)
            step = {`FCP_K_WR, `FCP_A_ZERO, 8'hF0};
        else
            step = fcp_step(op_r, idx_r);
    end

    // Unlock cycles drive zeros above A11; bank-addressed steps drive the bank bits there
    always @*
    begin
        case (asel)
            `FCP_A_555: amux = {{(AW-12){1'b0}}, `FCP_LO_555};
            `FCP_A_2AA: amux = {{(AW-12){1'b0}}, `FCP_LO_2AA};
            `FCP_A_B555: amux = {bank, `FCP_LO_555};
            `FCP_A_TGT: amux = tgt_r;
            `FCP_A_LOCK: amux = {bank, 4'h0, `FCP_LOCK_LO};
            `FCP_A_SECL: amux = {{(AW-8){1'b0}}, `FCP_SECL_LO};
            `FCP_A_B055: amux = {bank, `FCP_LO_055};
            default: amux = {AW{1'b0}};
        endcase
    end

    // ------------------------------------------------------------
    // Command acceptance and verify
    // ------------------------------------------------------------
    assign cmd_wr = reg_wr && (reg_addr == `FCP_REG_CMD);
    assign clr_wr = reg_wr && (reg_addr == `FCP_REG_STATUS);
    // Suspend, resume and query are only legal in the right mode
    assign refuse = (state_r != S_IDLE) || hw_reset_r
        || ((reg_wdata[4:0] == `FCP_OP_SUSPEND) && (!erase_r || susp_r))
        || ((reg_wdata[4:0] == `FCP_OP_RESUME) && !susp_r)
        || ((reg_wdata[4:0] == `FCP_OP_QUERY) && erase_r && !susp_r)
        || (reg_wdata[4:0] > `FCP_OP_SECP_STAT);
    assign need_one = (op_r == `FCP_OP_LOCK_PROG) || (op_r == `FCP_OP_SECP_PROG);
    assign need_zero = (op_r == `FCP_OP_LOCK_ERASE);
    assign verify_bad = (need_one && !rdata_r[0]) || (need_zero && rdata_r[0]);
    assign finish = (state_r == S_FETCH) && (kind == `FCP_K_END);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
                if (cmd_wr && !refuse)
                    state_nxt = S_FETCH;
            S_FETCH:
                case (kind)
                    `FCP_K_WR: state_nxt = S_WSETUP;
                    `FCP_K_RD: state_nxt = S_RLOW;
                    `FCP_K_WAIT: state_nxt = S_WGAP;
                    default: state_nxt = S_IDLE;
                endcase
            S_WSETUP: state_nxt = S_WLOW;
            S_WLOW:
                if (cnt_r == 16'h0000)
                    state_nxt = S_WHOLD;
            S_WHOLD: state_nxt = S_FETCH;
            S_RLOW:
                if (cnt_r == 16'h0000)
                    state_nxt = S_CHECK;
            S_WGAP:
                if (cnt_r == 16'h0000)
                    state_nxt = S_FETCH;
            S_CHECK: state_nxt = S_FETCH;
            default: state_nxt = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    // Walk the table; address set before the strobe falls, data held past its rise
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= S_IDLE;
            op_r <= 5'h00;
            idx_r <= 3'h0;
            cnt_r <= 16'h0000;
            retry_r <= 4'h0;
            rst_first_r <= 1'b0;
            rdata_r <= 16'h0000;
            flash_addr <= {AW{1'b0}};
            flash_dq_o <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            case (state_r)
                S_IDLE:
                    if (cmd_wr && !refuse)
                    begin
                        op_r <= reg_wdata[4:0];
                        idx_r <= 3'h0;
                        retry_r <= 4'h0;
                        rst_first_r <= 1'b0;
                    end
                S_FETCH:
                begin
                    flash_addr <= amux;
                    // Program data travels full width, commands in the low byte
                    if (op_r == `FCP_OP_PROG && idx_r == 3'd3 && !rst_first_r)
                        flash_dq_o <= data_r;
                    else
                        flash_dq_o <= {8'h00, dbyte};
                    if (kind == `FCP_K_WAIT)
                        cnt_r <= GAP_LOAD;
                    else if (kind == `FCP_K_RD)
                        cnt_r <= RD_LOAD;
                    else
                        cnt_r <= WE_LOAD;
                end
                S_WLOW, S_RLOW:
                begin
                    if (cnt_r != 16'h0000)
                        cnt_r <= cnt_r - 16'h0001;
                    if (state_r == S_RLOW && cnt_r == 16'h0000)
                        rdata_r <= dq_s2_r;
                end
                S_WGAP:
                    if (cnt_r != 16'h0000)
                        cnt_r <= cnt_r - 16'h0001;
                    else
                        idx_r <= idx_r + 3'd1;
                S_WHOLD:
                    // The injected reset does not consume a table step
                    if (rst_first_r)
                        rst_first_r <= 1'b0;
                    else
                        idx_r <= idx_r + 3'd1;
                S_CHECK:
                    // Reissue the whole sequence while retries remain
                    if (verify_bad && retry_r < MAX_RETRY)
                    begin
                        retry_r <= retry_r + 4'h1;
                        idx_r <= 3'h0;
                        rst_first_r <= need_zero;
                    end
                    else
                        idx_r <= idx_r + 3'd1;
                default:
                    idx_r <= idx_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flash strobes
    // ------------------------------------------------------------
    // Strobes come from flip-flops decoded from the next state
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            flash_reset_n <= 1'b0;
        end
        else
        begin
            flash_ce_n <= !((state_nxt == S_WSETUP) || (state_nxt == S_WLOW)
                || (state_nxt == S_WHOLD) || (state_nxt == S_RLOW));
            flash_we_n <= (state_nxt != S_WLOW);
            flash_oe_n <= (state_nxt != S_RLOW);
            flash_dq_oe <= (state_nxt == S_WSETUP) || (state_nxt == S_WLOW)
                || (state_nxt == S_WHOLD);
            flash_reset_n <= !hw_reset_r;
        end
    end

    // Two-stage synchroniser for the data pins
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
        end
        else
        begin
            dq_s1_r <= flash_dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Software registers and mode tracking
    // ------------------------------------------------------------
    // Sticky flags: a set in the same cycle as a clear wins
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tgt_r <= {AW{1'b0}};
            data_r <= 16'h0000;
            hw_reset_r <= 1'b0;
            done_r <= 1'b0;
            vfail_r <= 1'b0;
            refused_r <= 1'b0;
            secure_r <= 1'b0;
            susp_r <= 1'b0;
            erase_r <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `FCP_REG_ADDR)
                tgt_r <= reg_wdata[AW-1:0];
            if (reg_wr && reg_addr == `FCP_REG_DATA)
                data_r <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `FCP_REG_CTRL)
                hw_reset_r <= reg_wdata[0];
            done_r <= finish || (done_r && !(clr_wr && reg_wdata[`FCP_ST_DONE]));
            vfail_r <= (state_r == S_CHECK && verify_bad && retry_r >= MAX_RETRY)
                || (vfail_r && !(clr_wr && reg_wdata[`FCP_ST_VFAIL]));
            refused_r <= (cmd_wr && refuse)
                || (refused_r && !(clr_wr && reg_wdata[`FCP_ST_REFUSED]));
            // Modes follow the completed sequences and the reset pin
            if (hw_reset_r)
            begin
                secure_r <= 1'b0;
                susp_r <= 1'b0;
                erase_r <= 1'b0;
            end
            else if (reg_wr && reg_addr == `FCP_REG_CTRL && reg_wdata[1])
            begin
                susp_r <= 1'b0;
                erase_r <= 1'b0;
            end
            else if (finish)
            begin
                if (op_r == `FCP_OP_SEC_ENTRY)
                    secure_r <= 1'b1;
                if (op_r == `FCP_OP_SEC_EXIT || op_r == `FCP_OP_RESET)
                    secure_r <= 1'b0;
                if (op_r == `FCP_OP_SERASE)
                    erase_r <= 1'b1;
                if (op_r == `FCP_OP_SUSPEND)
                    susp_r <= 1'b1;
                if (op_r == `FCP_OP_RESUME)
                    susp_r <= 1'b0;
            end
        end
    end

    // Read data stand one cycle after the strobe; unmapped reads give zero
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `FCP_REG_ADDR: reg_rdata <= {{(32-AW){1'b0}}, tgt_r};
                `FCP_REG_DATA: reg_rdata <= {16'h0000, data_r};
                `FCP_REG_STATUS: reg_rdata <= {20'h00000, retry_r, 1'b0, erase_r, susp_r,
                    secure_r, refused_r, vfail_r, done_r, (state_r != S_IDLE)};
                `FCP_REG_RDATA: reg_rdata <= {16'h0000, rdata_r};
                `FCP_REG_CTRL: reg_rdata <= {31'h00000000, hw_reset_r};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end

endmodule
`default_nettype wire

// ### tb/fcp_props.sv
// Port checker for the flash command sequencer
`timescale 1ns/100ps
`default_nettype none
module fcp_props #(
    parameter AW = 21
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [AW-1:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    input wire logic flash_dq_oe,
    input wire logic [15:0] flash_dq_i,
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n,
    input wire logic flash_reset_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata stray");
    we_setup_a: assert property ($fell(flash_we_n) |-> !flash_ce_n && flash_dq_oe) else $error("we early");
    we_pulse_a: assert property ($fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n) else $error("we width");
    wr_hold_a: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_o)) else $error("wr moved");
    ce_after_a: assert property ($rose(flash_we_n) |-> !flash_ce_n ##1 flash_ce_n) else $error("ce order");
    cmd_byte_a: assert property (!flash_we_n && flash_addr[11:0] == 12'h555 |-> flash_dq_o[15:8] == 8'h00) else $error("upper byte");
    rd_width_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*5]) else $error("read short");
    no_clash_a: assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe) else $error("bus clash");
    idle_lines_a: assert property (flash_ce_n |-> flash_we_n && flash_oe_n) else $error("idle strobe");
    cover property ($fell(flash_we_n));
    cover property ($fell(flash_oe_n));
    cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind fcp_sequencer fcp_props #(.AW(AW)) u_props (.*);
`default_nettype wire

// ### tb/fcp_flash_model.sv
// Behavioural flash device decoding command cycles
`timescale 1ns/100ps
`default_nettype none
module fcp_flash_model (
    input wire logic [20:0] addr,
    input wire logic [15:0] dq_w,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic rst_n,
    output logic [15:0] dq_r
);
    logic [20:0] a_r; // Latched write address
    logic [1:0] step_r; // Unlock progress
    logic [7:0] mode_r; // Accepted command
    logic [511:0] lock_r = '0; // Sector lock bits
    logic frz_r = 0;
    logic secp_r = 0;
    logic sec_r;
    logic [15:0] rd_v;
    // Address taken at the later falling strobe
    always @(negedge we_n) if (!ce_n) a_r = addr;
    // Command decode on the first rising strobe
    always @(posedge we_n or negedge rst_n)
    begin
        if (!rst_n)
        begin
            step_r = 0;
            mode_r = 0;
            sec_r = 0;
        end
        else if (dq_w[7:0] == 8'hF0)
        begin
            step_r = 0;
            mode_r = 0;
        end
        else if (a_r[11:0] == 12'h555 && dq_w[7:0] == 8'hAA) step_r = 1;
        else if (step_r == 1 && a_r[11:0] == 12'h2AA && dq_w[7:0] == 8'h55) step_r = 2;
        else if (step_r == 2)
        begin
            step_r = 3;
            mode_r = dq_w[7:0];
            if (mode_r == 8'h88) sec_r = 1;
            if (mode_r == 8'h78) frz_r = 1;
        end
        else if (step_r == 3)
        begin
            if (mode_r == 8'h60 && dq_w[7:0] == 8'h68 && a_r[7:0] == 8'h02) lock_r[a_r[20:12]] = 1;
            if (mode_r == 8'h60 && dq_w[7:0] == 8'h60) lock_r = '0;
            if (mode_r == 8'h60 && dq_w[7:0] == 8'h68 && a_r[7:0] == 8'h1A) secp_r = 1;
            if (mode_r == 8'h90 && dq_w[7:0] == 8'h00) sec_r = 0;
        end
        else mode_r = 0;
    end
    // Status bits or array data; inverted pattern while released
    always @*
        if (mode_r == 8'h58) rd_v = {14'h0, frz_r, 1'b0};
        else if (mode_r == 8'h90 && addr[7:0] == 8'h03) rd_v = {9'h0, secp_r, 6'h0};
        else if (mode_r == 8'h60 && addr[7:0] == 8'h1A) rd_v = {15'h0, secp_r};
        else if (mode_r == 8'h90 || mode_r == 8'h60) rd_v = {15'h0, lock_r[addr[20:12]]};
        else rd_v = ~addr[15:0];
    assign dq_r = (!ce_n && !oe_n) ? rd_v : ~rd_v;
endmodule
`default_nettype wire

// ### tb/fcp_sequencer_bench.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/100ps
`default_nettype none
`include "fcp_map.vh"
module fcp_sequencer_bench;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic [4:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, rd_v;
    wire [31:0] reg_rdata;
    wire [20:0] f_a;
    wire [15:0] f_o, f_i;
    wire f_oe, f_ce, f_we, f_re, f_rst;
    int error_cnt = 0, n_compared = 0;
    always #20 clk = ~clk;
    fcp_sequencer #(.ERASE_GAP_CYC(32'd20)) u_dut (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .flash_addr(f_a), .flash_dq_o(f_o), .flash_dq_oe(f_oe),
        .flash_dq_i(f_i), .flash_ce_n(f_ce), .flash_we_n(f_we), .flash_oe_n(f_re),
        .flash_reset_n(f_rst));
    fcp_flash_model u_flash (.addr(f_a), .dq_w(f_o), .ce_n(f_ce), .we_n(f_we),
        .oe_n(f_re), .rst_n(f_rst), .dq_r(f_i));
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Clears sticky flags, starts an op, waits for idle, checks status flags
    task automatic op(input logic [4:0] c, input logic [20:0] a, input logic [31:0] st);
        int i;
        wr(`FCP_REG_STATUS, 32'h0E);
        wr(`FCP_REG_ADDR, {11'h0, a});
        wr(`FCP_REG_CMD, {27'h0, c});
        for (i = 0; i < 2000; i++)
        begin
            rd(`FCP_REG_STATUS);
            if (rd_v[0] === 1'b0) break;
        end
        chk(rd_v & 32'h7F, st);
    endtask
    task automatic lk(input logic [20:0] a, input logic [31:0] e);
        op(`FCP_OP_LOCK_STAT, a, 32'h2);
        rd(`FCP_REG_RDATA);
        chk(rd_v, e);
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`FCP_REG_STATUS);
        chk(rd_v, 32'h0);
        rd(5'h1C);
        chk(rd_v, 32'h0);
        op(`FCP_OP_READ, 21'h01234, 32'h2);
        rd(`FCP_REG_RDATA);
        chk(rd_v, 32'hEDCB);
        $display("test array read end");
        lk(21'h05000, 32'h0);
        op(`FCP_OP_LOCK_PROG, 21'h05000, 32'h2);
        lk(21'h05000, 32'h1);
        op(`FCP_OP_AUTOSEL, 21'h05002, 32'h2);
        rd(`FCP_REG_RDATA);
        chk(rd_v, 32'h1);
        lk(21'h06000, 32'h0);
        op(`FCP_OP_LOCK_ERASE, 21'h05000, 32'h2);
        lk(21'h05000, 32'h0);
        $display("test lock bits end");
        op(`FCP_OP_FREEZE, 21'h0, 32'h2);
        op(`FCP_OP_FREEZE_STAT, 21'h05000, 32'h2);
        rd(`FCP_REG_RDATA);
        chk(rd_v, 32'h2);
        op(`FCP_OP_SEC_ENTRY, 21'h0, 32'h12);
        op(`FCP_OP_SEC_EXIT, 21'h0, 32'h2);
        op(`FCP_OP_SECP_PROG, 21'h0, 32'h2);
        op(`FCP_OP_AUTOSEL, 21'h00003, 32'h2);
        rd(`FCP_REG_RDATA);
        chk(rd_v, 32'h40);
        $display("test freeze and secure end");
        op(`FCP_OP_RESUME, 21'h05000, 32'h8);
        op(`FCP_OP_SUSPEND, 21'h05000, 32'h8);
        op(`FCP_OP_QUERY, 21'h0, 32'h2);
        op(`FCP_OP_RESET, 21'h0, 32'h2);
        op(`FCP_OP_SERASE, 21'h05000, 32'h42);
        op(`FCP_OP_QUERY, 21'h0, 32'h48);
        op(`FCP_OP_SUSPEND, 21'h05000, 32'h62);
        op(`FCP_OP_RESUME, 21'h05000, 32'h42);
        wr(`FCP_REG_CTRL, 32'h1);
        op(`FCP_OP_RESET, 21'h0, 32'h8);
        chk({31'h0, f_rst}, 32'h0);
        $display("test refusals end");
        finish_test;
    end
    initial
    begin
        #(40 * 60000);
        error_cnt++;
        finish_test;
    end
endmodule
`default_nettype wire
